// [src/qdc_serial_ctrl.sv]
`timescale 1ns/100ps
// How it works
// - Select low: shift data on falling edges
// - Sixteenth edge captures bit, executes command
// - Extra edges ignored until select rises
// - Frame: address, mode, then twelve data bits
// - Data MSB first, straight binary codes
// - Channel codes range zero to 4095
// - Modes: load, load+update, all, power-down
// - Short frame discarded, nothing changes
// - Reset clears codes, outputs held zero
// - Mode 11 powers down all channels
// - Power-down address picks output termination
// - Power-down keeps channel registers intact
// - Normal frame wakes after wake-up delay
module qdc_serial_ctrl
   import qdc_pkg::*;
#(
   parameter int WAKE_CYCLES = QDC_WAKE_CYCLES
)
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          link_sclk,
   input  wire logic          link_rst,
   input  wire logic          frame_sel_n,
   input  wire logic          serial_din,
   input  wire logic [4:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output logic      [31:0]   avs_readdata,
   output logic               avs_waitrequest,
   output logic      [11:0]   out_code_a,
   output logic      [11:0]   out_code_b,
   output logic      [11:0]   out_code_c,
   output logic      [11:0]   out_code_d,
   output logic               outputs_active,
   output logic      [1:0]    out_termination
);

   // Link domain: falling edge shifter
   logic [15:0]          shift_reg;
   logic [QDC_CNT_BITS-1:0] bit_cnt_reg;
   logic [15:0]          frame_reg;
   logic                 frame_tgl_reg;
   logic [15:0]          frame_word;

   assign frame_word = {shift_reg[14:0], serial_din};

   // Select high aborts a frame and re-arms the counter
   always_ff @(negedge link_sclk or posedge frame_sel_n or posedge link_rst)
   begin
      if (link_rst)
      begin
         bit_cnt_reg <= '0;
         shift_reg   <= '0;
      end
      else if (frame_sel_n)
      begin
         bit_cnt_reg <= '0;
      end
      else if (bit_cnt_reg < QDC_CNT_BITS'(QDC_FRAME_BITS))
      begin
         shift_reg   <= frame_word;
         bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
   end

   always_ff @(negedge link_sclk or posedge link_rst)
   begin
      if (link_rst)
      begin
         frame_reg     <= '0;
         frame_tgl_reg <= 1'b0;
      end
      else if (!frame_sel_n && bit_cnt_reg == QDC_CNT_BITS'(QDC_FRAME_BITS - 1))
      begin
         frame_reg     <= frame_word;
         frame_tgl_reg <= ~frame_tgl_reg;
      end
   end

   // Toggle crossing; frame word is stable across the toggle
   logic       tgl_s1_reg;
   logic       tgl_s2_reg;
   logic       tgl_s3_reg;
   logic       tgl_s4_reg;
   logic       frame_evt;
   logic [15:0] cmd_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         tgl_s4_reg <= 1'b0;
      end
      else
      begin
         tgl_s1_reg <= frame_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         tgl_s4_reg <= tgl_s3_reg;
      end
   end

   // Command acts one cycle after its word is held locally
   assign frame_evt = tgl_s3_reg ^ tgl_s4_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
         cmd_reg <= '0;
      else if (tgl_s2_reg != tgl_s3_reg)
         cmd_reg <= frame_reg;
   end

   // Decode taken from the crossed word
   logic [1:0]  cmd_addr;
   logic [1:0]  cmd_mode;
   logic [11:0] cmd_data;
   assign cmd_addr = cmd_reg[QDC_ADDR_HI:QDC_ADDR_LO];
   assign cmd_mode = cmd_reg[QDC_MODE_HI:QDC_MODE_LO];
   assign cmd_data = cmd_reg[QDC_DATA_HI:0];

   // Channel registers and output latches
   logic [11:0] chan_reg [QDC_CHANNELS];
   logic [11:0] out_reg  [QDC_CHANNELS];
   logic        pdown_reg;
   logic        valid_seen_reg;
   logic [1:0]  term_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < QDC_CHANNELS; i++)
            chan_reg[i] <= QDC_CODE_RST;
      end
      else if (frame_evt)
      begin
         unique case (cmd_mode)
            QDC_MODE_LOAD,
            QDC_MODE_UPDATE: chan_reg[cmd_addr] <= cmd_data;
            QDC_MODE_ALL:
               for (int i = 0; i < QDC_CHANNELS; i++)
                  chan_reg[i] <= cmd_data;
            QDC_MODE_PDOWN: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < QDC_CHANNELS; i++)
            out_reg[i] <= QDC_CODE_RST;
      end
      else if (frame_evt && cmd_mode == QDC_MODE_UPDATE)
      begin
         for (int i = 0; i < QDC_CHANNELS; i++)
            out_reg[i] <= (i == int'(cmd_addr)) ? cmd_data : chan_reg[i];
      end
      else if (frame_evt && cmd_mode == QDC_MODE_ALL)
      begin
         for (int i = 0; i < QDC_CHANNELS; i++)
            out_reg[i] <= cmd_data;
      end
   end

   // Power-down state, termination and wake timer
   logic [15:0] wake_cnt_reg;
   logic        waking;
   assign waking = wake_cnt_reg != 16'h0000;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pdown_reg      <= 1'b0;
         term_reg       <= QDC_TERM_RST;
         valid_seen_reg <= 1'b0;
         wake_cnt_reg   <= '0;
      end
      else if (frame_evt && cmd_mode == QDC_MODE_PDOWN)
      begin
         pdown_reg      <= 1'b1;
         term_reg       <= cmd_addr;
         valid_seen_reg <= 1'b1;
         wake_cnt_reg   <= '0;
      end
      else if (frame_evt)
      begin
         valid_seen_reg <= 1'b1;
         if (pdown_reg)
         begin
            pdown_reg    <= 1'b0;
            wake_cnt_reg <= 16'(WAKE_CYCLES);
         end
      end
      else if (waking)
      begin
         wake_cnt_reg <= wake_cnt_reg - 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         outputs_active <= 1'b0;
      else
         outputs_active <= valid_seen_reg && !pdown_reg && !waking;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         out_termination <= QDC_TERM_RST;
      else if (term_reg == QDC_MODE_PDOWN)
         out_termination <= QDC_TERM_HIZ;
      else
         out_termination <= term_reg;
   end

   assign out_code_a = out_reg[0];
   assign out_code_b = out_reg[1];
   assign out_code_c = out_reg[2];
   assign out_code_d = out_reg[3];

   // Avalon slave: one wait cycle, answer on the second
   logic ack_reg;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read || avs_write) && !ack_reg;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         avs_readdata <= QDC_UNMAPPED;
      else if (avs_read && !ack_reg)
      begin
         unique case (avs_address)
            5'(QDC_OFS_CODE_A): avs_readdata <= {20'h0, chan_reg[0]};
            5'(QDC_OFS_CODE_B): avs_readdata <= {20'h0, chan_reg[1]};
            5'(QDC_OFS_CODE_C): avs_readdata <= {20'h0, chan_reg[2]};
            5'(QDC_OFS_CODE_D): avs_readdata <= {20'h0, chan_reg[3]};
            QDC_OFS_STATUS:
               avs_readdata <= {27'h0, out_termination, waking, pdown_reg,
                                outputs_active};
            default:            avs_readdata <= QDC_UNMAPPED;
         endcase
      end
   end

   // Assertions
   sequence s_pdown_frame;
      frame_evt && cmd_mode == QDC_MODE_PDOWN;
   endsequence

   sequence s_wake_frame;
      frame_evt && pdown_reg && cmd_mode != QDC_MODE_PDOWN;
   endsequence

   sequence s_pdown_then_off;
      pdown_reg ##1 !outputs_active;
   endsequence

   sequence s_last_edge;
      !frame_sel_n && bit_cnt_reg == QDC_CNT_BITS'(QDC_FRAME_BITS - 1);
   endsequence

   a_shift_in: assert property (@(negedge link_sclk) disable iff (link_rst)
      !frame_sel_n && bit_cnt_reg < QDC_CNT_BITS'(QDC_FRAME_BITS)
      |=> shift_reg[0] == $past(serial_din))
      else $error("serial bit not shifted in");

   a_frame_capture: assert property (@(negedge link_sclk) disable iff (link_rst)
      s_last_edge
      |=> frame_reg == $past(frame_word))
      else $error("frame word not captured on last edge");

   a_tail_ignored: assert property (@(negedge link_sclk) disable iff (link_rst)
      !frame_sel_n && bit_cnt_reg == QDC_CNT_BITS'(QDC_FRAME_BITS)
      |=> $stable(shift_reg) && $stable(frame_tgl_reg))
      else $error("edge after frame end was used");

   a_abort_silent: assert property (@(negedge link_sclk) disable iff (link_rst)
      frame_sel_n || bit_cnt_reg != QDC_CNT_BITS'(QDC_FRAME_BITS - 1)
      |=> $stable(frame_tgl_reg))
      else $error("short frame produced a command");

   a_evt_single: assert property (@(posedge clk) disable iff (rst)
      frame_evt |=> !frame_evt)
      else $error("one frame acted twice");

   a_pdown_keeps_regs: assert property (@(posedge clk) disable iff (rst)
      s_pdown_frame
      |=> chan_reg[0] == $past(chan_reg[0]) && chan_reg[1] == $past(chan_reg[1])
          && chan_reg[2] == $past(chan_reg[2]) && chan_reg[3] == $past(chan_reg[3]))
      else $error("channel register changed on power-down");

   a_pdown_enters: assert property (@(posedge clk) disable iff (rst)
      s_pdown_frame |=> s_pdown_then_off)
      else $error("power-down not entered");

   a_term_select: assert property (@(posedge clk) disable iff (rst)
      s_pdown_frame ##0 cmd_addr == QDC_TERM_2K5
      |=> ##1 out_termination == QDC_TERM_2K5)
      else $error("termination not selected");

   a_term_hiz_alias: assert property (@(posedge clk) disable iff (rst)
      s_pdown_frame ##0 cmd_addr == 2'h3
      |=> ##1 out_termination == QDC_TERM_HIZ)
      else $error("address three not high impedance");

   a_wake_delay: assert property (@(posedge clk) disable iff (rst)
      s_wake_frame |=> !outputs_active [*8])
      else $error("outputs returned before wake-up delay");

   a_active_return: assert property (@(posedge clk) disable iff (rst)
      valid_seen_reg && !pdown_reg && !waking && !frame_evt
      |=> outputs_active)
      else $error("outputs not active after wake-up");

   a_load_target: assert property (@(posedge clk) disable iff (rst)
      frame_evt && cmd_mode == QDC_MODE_LOAD
      |=> chan_reg[cmd_addr] == $past(cmd_data))
      else $error("load did not reach addressed register");

   a_read_code: assert property (@(posedge clk) disable iff (rst)
      avs_read && !ack_reg && avs_address == 5'h00 && !frame_evt
      |=> avs_readdata == {20'h0, chan_reg[0]})
      else $error("read data does not show channel code");
   a_all_load: assert property (@(posedge clk) disable iff (rst)
      frame_evt && cmd_mode == QDC_MODE_ALL |=> out_reg[3] == $past(cmd_data)
      && chan_reg[0] == $past(cmd_data))
      else $error("load all failed");
   a_load_no_update: assert property (@(posedge clk) disable iff (rst)
      frame_evt && cmd_mode == QDC_MODE_LOAD |=> out_reg[1] == $past(out_reg[1]))
      else $error("load only changed outputs");
   a_update_addr: assert property (@(posedge clk) disable iff (rst)
      frame_evt && cmd_mode == QDC_MODE_UPDATE && cmd_addr == 2'h2
      |=> out_reg[2] == $past(cmd_data) && chan_reg[2] == $past(cmd_data))
      else $error("update of channel C failed");
   a_reset_zero: assert property (@(posedge clk)
      $past(rst) && !valid_seen_reg |-> !outputs_active && out_reg[0] == QDC_CODE_RST)
      else $error("outputs not held at zero after reset");

endmodule

// [src/qdc_pkg.sv]
package qdc_pkg;
   localparam int QDC_FRAME_BITS  = 16;
   localparam int QDC_CODE_BITS   = 12;
   localparam int QDC_CHANNELS    = 4;
   localparam int QDC_CNT_BITS    = 5;
   // Frame fields, first bit shifted in sits at the top
   localparam int QDC_ADDR_HI     = 15;
   localparam int QDC_ADDR_LO     = 14;
   localparam int QDC_MODE_HI     = 13;
   localparam int QDC_MODE_LO     = 12;
   localparam int QDC_DATA_HI     = 11;
   localparam logic [11:0] QDC_CODE_RST = 12'h000;
   localparam logic [1:0]  QDC_MODE_LOAD   = 2'h0;
   localparam logic [1:0]  QDC_MODE_UPDATE = 2'h1;
   localparam logic [1:0]  QDC_MODE_ALL    = 2'h2;
   localparam logic [1:0]  QDC_MODE_PDOWN  = 2'h3;
   // Termination codes
   localparam logic [1:0]  QDC_TERM_HIZ   = 2'h0;
   localparam logic [1:0]  QDC_TERM_2K5   = 2'h1;
   localparam logic [1:0]  QDC_TERM_100K  = 2'h2;
   localparam logic [1:0]  QDC_TERM_RST   = 2'h0;
   // Wake-up delay, microseconds, and cycles at 100 MHz
   localparam int QDC_CLK_MHZ      = 100;
   localparam int QDC_WAKE_US      = 6;
   localparam int QDC_WAKE_CYCLES  = QDC_WAKE_US * QDC_CLK_MHZ;
   // Register map, word aligned byte addresses
   localparam logic [3:0] QDC_OFS_CODE_A  = 4'h0;
   localparam logic [3:0] QDC_OFS_CODE_B  = 4'h4;
   localparam logic [3:0] QDC_OFS_CODE_C  = 4'h8;
   localparam logic [3:0] QDC_OFS_CODE_D  = 4'hc;
   localparam logic [4:0] QDC_OFS_STATUS  = 5'h10;
   localparam logic [4:0] QDC_OFS_CTRL    = 5'h14;
   localparam logic [31:0] QDC_UNMAPPED   = 32'h0000_0000;
endpackage

// [bench/qdc_host_model.sv]
`timescale 1ns/100ps
module qdc_host_model
#(
   parameter int HALF_NS = 40
)
(
   output logic link_sclk,
   output logic frame_sel_n,
   output logic serial_din
);
   initial
   begin
      link_sclk   = 1'b1;
      frame_sel_n = 1'b1;
      serial_din  = 1'b0;
   end

   // Sends the top n bits; clock stands high outside frames
   task automatic send_frame(input logic [23:0] word, input int n);
      #7;
      frame_sel_n = 1'b0;  // Select falls while clock high
      for (int i = 0; i < n; i++)
      begin
         serial_din = word[23-i];  // MSB first
         #(HALF_NS) link_sclk = 1'b0;
         #(HALF_NS) link_sclk = 1'b1;
      end
      serial_din = 1'b0;  // Data parked low
      #(HALF_NS) frame_sel_n = 1'b1;
      #(2*HALF_NS);  // Select high time before next frame
   endtask
endmodule

// [bench/qdc_serial_ctrl_tb_top.sv]
`timescale 1ns/100ps
module qdc_serial_ctrl_tb_top;
   import qdc_pkg::*;
   localparam int WAKE = 20;
   localparam logic [1:0] TERM_EXP [4] = '{QDC_TERM_HIZ, QDC_TERM_2K5, QDC_TERM_100K, QDC_TERM_HIZ};
   logic        clk           = 1'b0;
   logic        rst           = 1'b1;
   logic [4:0]  avs_address   = 5'h00;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic        link_sclk;
   logic        frame_sel_n;
   logic        serial_din;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [11:0] out_code_a;
   logic [11:0] out_code_b;
   logic [11:0] out_code_c;
   logic [11:0] out_code_d;
   logic        outputs_active;
   logic [1:0]  out_termination;
   logic [31:0] rd;
   logic [11:0] exp_reg [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
   logic [11:0] exp_out [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
   int          bad_count   = 0;
   int          check_count = 0;
   int          cycles      = 0;

   always #5 clk = ~clk;

   qdc_serial_ctrl #(.WAKE_CYCLES(WAKE)) qdc_serial_ctrl_inst (
      .clk(clk), .rst(rst), .link_sclk(link_sclk), .link_rst(rst),
      .frame_sel_n(frame_sel_n), .serial_din(serial_din),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .out_code_a(out_code_a),
      .out_code_b(out_code_b), .out_code_c(out_code_c), .out_code_d(out_code_d),
      .outputs_active(outputs_active), .out_termination(out_termination));

   qdc_host_model qdc_host_model_inst (
      .link_sclk(link_sclk), .frame_sel_n(frame_sel_n), .serial_din(serial_din));

   task automatic stop_test();
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] addr, output logic [31:0] data);
      @(posedge clk);
      avs_address   <= addr;
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_writedata <= 32'hffff_ffff;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      data = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Frame is address, mode, code, then ones on any extra edges
   task automatic frame(input logic [1:0] ch, input logic [1:0] md,
                        input logic [11:0] code, input int n);
      qdc_host_model_inst.send_frame({ch, md, code, 8'hff}, n);
      repeat (2) @(posedge clk);
   endtask

   task automatic check_regs();
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b0, 5'(i * 4), rd);
         check(rd, {20'h00000, exp_reg[i]});
      end
   endtask

   task automatic check_outs();
      check({20'h00000, out_code_a}, {20'h00000, exp_out[0]});
      check({20'h00000, out_code_b}, {20'h00000, exp_out[1]});
      check({20'h00000, out_code_c}, {20'h00000, exp_out[2]});
      check({20'h00000, out_code_d}, {20'h00000, exp_out[3]});
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      check_regs();
      check_outs();
      check({31'h0, outputs_active}, 32'h0);
      frame(2'h1, QDC_MODE_LOAD, 12'habc, 16);
      exp_reg[1] = 12'habc;
      check_regs();
      check_outs();
      frame(2'h0, QDC_MODE_UPDATE, 12'h123, 20);
      exp_reg[0] = 12'h123;
      exp_out = exp_reg;
      check_regs();
      check_outs();
      frame(2'h2, QDC_MODE_ALL, 12'h000, 15);
      check_regs();
      check_outs();
      frame(2'h3, QDC_MODE_ALL, 12'hfff, 16);
      exp_reg = '{12'hfff, 12'hfff, 12'hfff, 12'hfff};
      exp_out = exp_reg;
      check_outs();
      bus(1'b1, 5'(QDC_OFS_CODE_A), rd);
      bus(1'b0, 5'h18, rd);
      check(rd, QDC_UNMAPPED);
      frame(2'h1, QDC_MODE_LOAD, 12'h246, 16);
      exp_reg[1] = 12'h246;
      check_regs();
      for (int t = 0; t < 4; t++)
      begin
         frame(2'(t), QDC_MODE_PDOWN, 12'h5a5, 16);
         check({30'h0, out_termination}, {30'h0, TERM_EXP[t]});
         check({31'h0, outputs_active}, 32'h0);
         check_regs();
      end
      bus(1'b0, QDC_OFS_STATUS, rd);
      check(rd, 32'h0000_0002);
      frame(2'h2, QDC_MODE_UPDATE, 12'h321, 16);
      exp_reg[2] = 12'h321;
      exp_out = exp_reg;
      check({31'h0, outputs_active}, 32'h0);
      repeat (WAKE + 10) @(posedge clk);
      check({31'h0, outputs_active}, 32'h1);
      check_outs();
      check_regs();
      bus(1'b0, QDC_OFS_STATUS, rd);
      check(rd, 32'h0000_0001);
      stop_test();
   end
endmodule
